// *** src/bipf_reader.v ***
// Binary input channel: static level or pulse-frequency reader with APB registers
`timescale 1ns/100ps
`default_nettype none
`include "bipf_consts.vh"

module bipf_reader #(
  parameter GATE_CYCLES = `BIPF_GATE_TIME_MS * 100000,
  parameter HIST_AW = 6
) (
  input wire core_clk_i,
  input wire sys_rst_i,
  input wire bin_in_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg pready_o,
  output reg [31:0] prdata_o,
  output reg pslverr_o,
  output reg active_o,
  output reg result_valid_o,
  output reg [31:0] result_o
);

  // ===================================================================
  // Configuration
  reg en;
  reg sig_pfm;
  reg pol_high;
  reg [1:0] mode;
  reg [1:0] decs;
  reg [16:0] fmax;
  reg [31:0] lrv;
  reg [31:0] urv;
  reg [5:0] damp;
  reg [31:0] name_w [0:3];
  reg [31:0] unit_w [0:3];
  reg hist_clr;

  // ===================================================================
  // Input synchroniser
  reg s1;
  reg s2;
  reg s3;
  reg lvl;

  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      lvl <= 1'b0;
    end else begin
      s1 <= bin_in_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        lvl <= s3;
      end
    end
  end

  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      active_o <= 1'b0;
    end else begin
      active_o <= en & ~sig_pfm & (lvl == pol_high);
    end
  end

  // ===================================================================
  // Gate counter
  wire run_pfm;
  wire smp_stb;
  wire [15:0] smp_cnt;

  assign run_pfm = en & sig_pfm;

  bipf_gate_counter #(
    .GATE_CYCLES(GATE_CYCLES)
  ) u_gate (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .run_i(run_pfm),
    .level_i(lvl),
    .fmax_i(fmax),
    .smp_stb_o(smp_stb),
    .smp_cnt_o(smp_cnt)
  );

  // ===================================================================
  // Floating average history, one sample per gate second
  reg [15:0] hist [0:(1 << HIST_AW) - 1];
  reg [HIST_AW-1:0] wp;
  reg [6:0] fill;
  reg [22:0] sum;
  reg [15:0] last_cnt;
  wire [6:0] win;
  wire [15:0] oldest;
  wire [6:0] neff;

  assign win = (damp == 6'h0) ? 7'h1 : {1'b0, damp};
  assign oldest = hist[wp - win[HIST_AW-1:0]];
  assign neff = (fill < win) ? fill : win;

  always @(posedge core_clk_i) begin
    if (smp_stb) begin
      hist[wp] <= smp_cnt;
    end
  end

  // Window change restarts the average rather than mixing stale samples
  always @(posedge core_clk_i) begin
    if (sys_rst_i || hist_clr || !run_pfm) begin
      wp <= {HIST_AW{1'b0}};
      fill <= 7'h0;
      sum <= 23'h0;
      last_cnt <= 16'h0;
    end else if (smp_stb) begin
      wp <= wp + 1'b1;
      last_cnt <= smp_cnt;
      if (fill >= win) begin
        sum <= sum + {7'h0, smp_cnt} - {7'h0, oldest};
      end else begin
        sum <= sum + {7'h0, smp_cnt};
        fill <= fill + 7'h1;
      end
    end
  end

  // ===================================================================
  // Scaling divider: value = offset + span * avg / fmax
  reg go;
  reg busy;
  reg [5:0] it;
  reg [47:0] dq;
  reg [31:0] rem;
  reg [31:0] den;
  reg [31:0] qscale;
  wire ranged;
  wire [47:0] span;
  wire [47:0] num;
  wire [31:0] scale;
  wire [32:0] trial;
  wire [31:0] qmul;

  assign ranged = (mode == `BIPF_MODE_PARAM) || (mode == `BIPF_MODE_FLOW);
  // Frequency mode uses fmax as span so the ratio cancels to the average
  assign span = ranged ? {16'h0, urv - lrv} : {31'h0, fmax};
  assign num = span * {25'h0, sum} * {14'h0, `BIPF_CENTI};
  assign scale = (decs == 2'h0) ? 32'h64 : ((decs == 2'h1) ? 32'ha : 32'h1);
  assign trial = {rem, dq[47]};
  assign qmul = dq[31:0] * qscale;

  always @(posedge core_clk_i) begin
    if (sys_rst_i || !run_pfm) begin
      go <= 1'b0;
      busy <= 1'b0;
      it <= 6'h0;
      dq <= 48'h0;
      rem <= 32'h0;
      den <= 32'h1;
      qscale <= 32'h1;
      result_valid_o <= 1'b0;
      result_o <= 32'h0;
    end else begin
      go <= smp_stb;
      if (go && !busy) begin
        busy <= 1'b1;
        it <= 6'h30;
        dq <= num;
        rem <= 32'h0;
        den <= {15'h0, fmax} * {25'h0, neff} * scale;
        qscale <= scale;
      end else if (busy && it != 6'h0) begin
        it <= it - 6'h1;
        if (trial >= {1'b0, den}) begin
          rem <= trial[31:0] - den;
          dq <= {dq[46:0], 1'b1};
        end else begin
          rem <= trial[31:0];
          dq <= {dq[46:0], 1'b0};
        end
      end else if (busy) begin
        busy <= 1'b0;
        result_valid_o <= 1'b1;
        // Truncation to the chosen decimals, lower value as the zero point in parameter and flow modes, zero in frequency mode
        result_o <= (ranged ? lrv : 32'h0) + qmul;
      end
    end
  end

  // ===================================================================
  // APB slave, one wait-free access cycle after setup
  wire [7:0] ofs;
  wire in_page;
  wire str_hit;
  wire hit;
  wire wr_en;
  reg [31:0] rd;
  integer k;

  assign ofs = paddr_i[7:0];
  assign in_page = (paddr_i[11:8] == 4'h0) && (paddr_i[1:0] == 2'b00);
  assign str_hit = (ofs[7:4] == `BIPF_NAME_HI) || (ofs[7:4] == `BIPF_UNIT_HI);
  assign hit = in_page && (str_hit || (ofs <= `BIPF_OFS_VAL));
  assign wr_en = psel_i & penable_i & pready_o & pwrite_i & hit;

  always @* begin
    rd = 32'h0;
    if (ofs[7:4] == `BIPF_NAME_HI) begin
      rd = name_w[ofs[3:2]];
    end else if (ofs[7:4] == `BIPF_UNIT_HI) begin
      rd = unit_w[ofs[3:2]];
    end else begin
      case (ofs)
        `BIPF_OFS_CTRL: rd = {22'h0, decs, 2'b00, mode, 1'b0, pol_high, sig_pfm, en};
        `BIPF_OFS_FMAX: rd = {15'h0, fmax};
        `BIPF_OFS_LRV: rd = lrv;
        `BIPF_OFS_URV: rd = urv;
        `BIPF_OFS_DAMP: rd = {26'h0, damp};
        `BIPF_OFS_STAT: rd = {29'h0, lvl, result_valid_o, active_o};
        `BIPF_OFS_FREQ: rd = {16'h0, last_cnt} * 32'h64;
        `BIPF_OFS_VAL: rd = result_o;
        default: rd = 32'h0;
      endcase
    end
  end

  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0;
      pslverr_o <= 1'b0;
    end else if (psel_i && !penable_i) begin
      pready_o <= 1'b1;
      prdata_o <= hit ? rd : 32'h0;
      pslverr_o <= ~hit;
    end else begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0;
      pslverr_o <= 1'b0;
    end
  end

  // ===================================================================
  // Register writes, out-of-range values clamped to the legal span, except mode 3 which falls back to frequency mode
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      en <= `BIPF_RST_EN;
      sig_pfm <= `BIPF_RST_PFM;
      pol_high <= `BIPF_RST_POL;
      mode <= `BIPF_RST_MODE;
      decs <= `BIPF_RST_DEC;
      fmax <= `BIPF_FMAX_MAX;
      lrv <= 32'h0;
      urv <= 32'h0;
      damp <= 6'h0;
      hist_clr <= 1'b0;
      for (k = 0; k < 4; k = k + 1) begin
        name_w[k] <= 32'h0;
        unit_w[k] <= 32'h0;
      end
    end else begin
      hist_clr <= 1'b0;
      if (wr_en) begin
        if (ofs[7:4] == `BIPF_NAME_HI) begin
          name_w[ofs[3:2]] <= pwdata_i;
        end else if (ofs[7:4] == `BIPF_UNIT_HI) begin
          unit_w[ofs[3:2]] <= pwdata_i;
        end else begin
          case (ofs)
            `BIPF_OFS_CTRL: begin
              en <= pwdata_i[`BIPF_CTRL_EN];
              sig_pfm <= pwdata_i[`BIPF_CTRL_PFM];
              pol_high <= pwdata_i[`BIPF_CTRL_POL];
              mode <= (pwdata_i[`BIPF_CTRL_MODE_LO+1:`BIPF_CTRL_MODE_LO] == 2'h3) ?
                      `BIPF_MODE_FREQ : pwdata_i[`BIPF_CTRL_MODE_LO+1:`BIPF_CTRL_MODE_LO];
              decs <= (pwdata_i[`BIPF_CTRL_DEC_LO+1:`BIPF_CTRL_DEC_LO] == 2'h3) ?
                      2'h2 : pwdata_i[`BIPF_CTRL_DEC_LO+1:`BIPF_CTRL_DEC_LO];
              hist_clr <= 1'b1;
            end
            `BIPF_OFS_FMAX: begin
              if (pwdata_i < {15'h0, `BIPF_FMAX_MIN}) begin
                fmax <= `BIPF_FMAX_MIN;
              end else if (pwdata_i > {15'h0, `BIPF_FMAX_MAX}) begin
                fmax <= `BIPF_FMAX_MAX;
              end else begin
                fmax <= pwdata_i[16:0];
              end
              hist_clr <= 1'b1;
            end
            `BIPF_OFS_LRV: begin
              if ($signed(pwdata_i) < $signed(`BIPF_LRV_MIN)) begin
                lrv <= `BIPF_LRV_MIN;
              end else if ($signed(pwdata_i) > 0) begin
                lrv <= 32'h0;
              end else begin
                lrv <= pwdata_i;
              end
            end
            `BIPF_OFS_URV: begin
              if ($signed(pwdata_i) < 0) begin
                urv <= 32'h0;
              end else if (pwdata_i > `BIPF_URV_MAX) begin
                urv <= `BIPF_URV_MAX;
              end else begin
                urv <= pwdata_i;
              end
            end
            `BIPF_OFS_DAMP: begin
              damp <= (pwdata_i > {26'h0, `BIPF_DAMP_MAX}) ? `BIPF_DAMP_MAX : pwdata_i[5:0];
              hist_clr <= 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

endmodule // bipf_reader
`default_nettype wire

// *** src/bipf_consts.vh ***
// Constants for the binary input pulse-frequency reader channel
`ifndef BIPF_CONSTS_VH
`define BIPF_CONSTS_VH

// =====================================================================
// Register byte offsets
`define BIPF_OFS_CTRL 8'h00
`define BIPF_OFS_FMAX 8'h04
`define BIPF_OFS_LRV 8'h08
`define BIPF_OFS_URV 8'h0c
`define BIPF_OFS_DAMP 8'h10
`define BIPF_OFS_STAT 8'h14
`define BIPF_OFS_FREQ 8'h18
`define BIPF_OFS_VAL 8'h1c
`define BIPF_NAME_HI 4'h2
`define BIPF_UNIT_HI 4'h3

// =====================================================================
// Control fields
`define BIPF_CTRL_EN 0
`define BIPF_CTRL_PFM 1
`define BIPF_CTRL_POL 2
`define BIPF_CTRL_MODE_LO 4
`define BIPF_CTRL_DEC_LO 8

// =====================================================================
// Modes and reset values (values in hundredths)
`define BIPF_MODE_FREQ 2'h0
`define BIPF_MODE_PARAM 2'h1
`define BIPF_MODE_FLOW 2'h2
`define BIPF_RST_EN 1'b1
`define BIPF_RST_PFM 1'b0
`define BIPF_RST_POL 1'b1
`define BIPF_RST_MODE 2'h0
`define BIPF_RST_DEC 2'h2
`define BIPF_FMAX_MIN 17'h02710
`define BIPF_FMAX_MAX 17'h186a0
`define BIPF_LRV_MIN 32'hfffcf2c0
`define BIPF_URV_MAX 32'h000f4240
`define BIPF_DAMP_MAX 6'h3c

// =====================================================================
// Timing
`define BIPF_CLK_HZ 34'h05f5e100
`define BIPF_GATE_TIME_MS 1000
`define BIPF_CENTI 34'h064
`define BIPF_FILT_LIMIT (`BIPF_CLK_HZ * `BIPF_CENTI)

`endif

// *** src/bipf_gate_counter.v ***
// Edge counter over a fixed gate with a maximum-frequency pulse filter
`timescale 1ns/100ps
`default_nettype none
`include "bipf_consts.vh"

module bipf_gate_counter #(
  parameter GATE_CYCLES = 100000000
) (
  input wire core_clk_i,
  input wire sys_rst_i,
  input wire run_i,
  input wire level_i,
  input wire [16:0] fmax_i,
  output reg smp_stb_o,
  output reg [15:0] smp_cnt_o
);

  reg prev;
  reg [26:0] gcnt;
  reg [15:0] cnt;
  reg [33:0] acc;
  wire rise;
  wire accept;
  wire gate_end;

  assign rise = level_i & ~prev;
  // Edge only counts once a full period at fmax has passed since the last one
  assign accept = rise & (acc >= `BIPF_FILT_LIMIT);
  assign gate_end = (gcnt == GATE_CYCLES - 1);

  always @(posedge core_clk_i) begin
    if (sys_rst_i || !run_i) begin
      prev <= 1'b0;
      gcnt <= 27'h0;
      cnt <= 16'h0;
      acc <= `BIPF_FILT_LIMIT;
      smp_stb_o <= 1'b0;
      smp_cnt_o <= 16'h0;
    end else begin
      prev <= level_i;
      if (accept) begin
        acc <= 34'h0;
      end else if (acc < `BIPF_FILT_LIMIT) begin
        acc <= acc + {17'h0, fmax_i};
      end
      smp_stb_o <= gate_end;
      if (gate_end) begin
        gcnt <= 27'h0;
        smp_cnt_o <= cnt + {15'h0, accept};
        cnt <= 16'h0;
      end else begin
        gcnt <= gcnt + 27'h1;
        cnt <= cnt + {15'h0, accept};
      end
    end
  end

endmodule // bipf_gate_counter
`default_nettype wire

// *** tb/bipf_reader_chk.sv ***
// Port-level checker for the pulse-frequency reader channel
`timescale 1ns/100ps
`default_nettype none
`include "bipf_consts.vh"
module bipf_reader_chk #(
  parameter GATE_CYCLES = 2000,
  parameter HIST_AW = 6
) (
  input wire core_clk_i,
  input wire sys_rst_i,
  input wire bin_in_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire pready_o,
  input wire [31:0] prdata_o,
  input wire pslverr_o,
  input wire active_o,
  input wire result_valid_o,
  input wire [31:0] result_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // ==========================================================
  // Bus answer
  AST_SETUP_ANS: assert property (psel_i && !penable_i |=> pready_o) else $error("no answer after setup");
  AST_RDY_PULSE: assert property (pready_o |=> !pready_o) else $error("ready held too long");
  AST_IDLE_ZERO: assert property (!pready_o |-> prdata_o == 32'h0 && !pslverr_o) else $error("bus data outside answer");
  AST_ERR_WITH_RDY: assert property (pslverr_o |-> pready_o) else $error("error without ready");
  AST_ERR_ADDR: assert property (psel_i && !penable_i && (paddr_i[11:8] != 4'h0 || paddr_i[1:0] != 2'h0)
    |=> pslverr_o) else $error("bad address not refused");
  // ==========================================================
  // Channel behaviour
  AST_RST_OUT: assert property ($fell(sys_rst_i) |-> !active_o && !result_valid_o && result_o == 32'h0)
    else $error("outputs not clear after reset");
  AST_STATIC_NO_RESULT: assert property (!(active_o && result_valid_o)) else $error("static and result");
  AST_DISABLE: assert property (psel_i && penable_i && pready_o && pwrite_i && paddr_i == {4'h0, `BIPF_OFS_CTRL}
    && !pwdata_i[`BIPF_CTRL_EN] |-> ##[1:3] (!active_o && !result_valid_o)) else $error("disable ignored");
  AST_VALUE_READ: assert property (pready_o && !pwrite_i && paddr_i == {4'h0, `BIPF_OFS_VAL}
    |-> prdata_o == $past(result_o)) else $error("value register differs from result");
  cover property ($rose(result_valid_o));
  cover property (pslverr_o);
  cover property ($rose(active_o));
endmodule // bipf_reader_chk
bind bipf_reader bipf_reader_chk #(.GATE_CYCLES(GATE_CYCLES), .HIST_AW(HIST_AW)) bipf_reader_chk_i (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .bin_in_i(bin_in_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o), .active_o(active_o),
  .result_valid_o(result_valid_o), .result_o(result_o));
`default_nettype wire

// *** tb/bipf_pulse_src.sv ***
// Far-side model: switch level or fast pulse train
`timescale 1ns/100ps
`default_nettype none
module bipf_pulse_src #(
  parameter int HALF = 50
) (
  input wire core_clk_i,
  input wire pulse_i,
  input wire level_i,
  output var logic pin_o
);
  int cnt = 0;
  initial pin_o = 1'b0;
  // Square wave far above any max frequency, so only the filter limits counts
  always @(posedge core_clk_i) begin
    if (!pulse_i) begin
      pin_o <= level_i;
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      pin_o <= ~pin_o;
      cnt <= 0;
    end else
      cnt <= cnt + 1;
  end
endmodule // bipf_pulse_src
`default_nettype wire

// *** tb/binary_input_pulse_frequency_reader_test.sv ***
// Self-checking bench for the pulse-frequency reader channel
`timescale 1ns/100ps
`default_nettype none
`include "bipf_consts.vh"
module binary_input_pulse_frequency_reader_test;
  localparam int G = 3000;
  localparam int FMAX = 100000;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, pulse_on = 1'b0, lvl = 1'b0, en, pl, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  wire pin, pready, pslverr, active, rvalid;
  wire [31:0] prdata, result;
  int failures = 0, tests_run = 0, cyc = 0;
  int q[$];
  logic [11:0] ta [0:8] = '{12'h004, 12'h004, 12'h008, 12'h008, 12'h00c, 12'h00c, 12'h010, 12'h020, 12'h03c};
  logic [31:0] tw [0:8] = '{32'h1388, 32'h30d40, 32'hfffb6c20, 32'h5, 32'hfffffffb, 32'h1e8480, 32'h64,
    32'h70726573, 32'h68506120};
  logic [31:0] te [0:8] = '{32'h2710, 32'h186a0, 32'hfffcf2c0, 32'h0, 32'h0, 32'hf4240, 32'h3c,
    32'h70726573, 32'h68506120};
  logic [31:0] re [0:4] = '{32'h205, 32'h186a0, 32'h0, 32'h0, 32'h0};

  always #5 core_clk_i = ~core_clk_i;
  bipf_pulse_src bipf_pulse_src_i (.core_clk_i(core_clk_i), .pulse_i(pulse_on), .level_i(lvl), .pin_o(pin));
  bipf_reader #(.GATE_CYCLES(G)) bipf_reader_i (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .bin_in_i(pin), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr), .active_o(active),
    .result_valid_o(rvalid), .result_o(result));

  task automatic finish_test;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic mism(string m);
    $display("mismatch at %0t: %s", $time, m);
    failures++;
  endtask
  task automatic cmp_val(logic [31:0] g, logic [31:0] e, string m);
    tests_run++;
    if (g !== e) mism(m);
  endtask
  task automatic cmp_bit(logic g, logic e, string m);
    tests_run++;
    if (g !== e) mism(m);
  endtask

  // ==========================================================
  // Bus master: request held until pready is sampled high at a rising edge
  task automatic apb(logic [11:0] a, logic w, logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk_i);
    pen <= 1'b1;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) mism("no ready");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask

  task automatic do_reset;
    sys_rst_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
  endtask

  // ==========================================================
  // Reference: floating average of gate counts, then linear range mapping
  function automatic logic [31:0] model(int mode, int lrv, int urv, int dec, int damp, int cnt);
    int n, sum, sc, span;
    longint v;
    n = (damp > 1) ? damp : 1;
    q.push_back(cnt);
    if (q.size() > n) void'(q.pop_front());
    sum = 0;
    foreach (q[i]) sum += q[i];
    sc = (dec == 2) ? 1 : (dec == 1) ? 10 : 100;
    span = (mode == 0) ? FMAX : urv - lrv;
    v = longint'(span) * sum * 100 / (longint'(FMAX) * q.size() * sc);
    return 32'(((mode == 0) ? 0 : lrv) + int'(v) * sc);
  endfunction

  task automatic run_pfm(int mode, int lrv, int urv, int dec, int damp);
    int n;
    n = 0;
    do_reset;
    q.delete();
    pulse_on <= 1'b1;
    apb(12'h008, 1'b1, lrv);
    apb(12'h00c, 1'b1, urv);
    apb(12'h010, 1'b1, damp);
    apb(12'h000, 1'b1, 32'h7 | (mode << 4) | (dec << 8));
    while (rvalid !== 1'b1 && n < 2 * G) begin
      @(posedge core_clk_i);
      n++;
    end
    if (rvalid !== 1'b1) mism("no result");
    repeat (10) @(posedge core_clk_i);
    // One edge in the first gate; the filter then blocks for 100000 cycles
    for (int g = 0; g < 3; g++) begin
      cmp_val(result, model(mode, lrv, urv, dec, damp, (g == 0) ? 1 : 0), "gate result");
      if (g == 0) begin
        apb(12'h018, 1'b0, 32'h0);
        cmp_val(rd, 32'h64, "frequency register");
      end
      repeat (G) @(posedge core_clk_i);
    end
    apb(12'h01c, 1'b0, 32'h0);
    cmp_val(rd, model(mode, lrv, urv, dec, damp, 0), "value register");
    apb(12'h000, 1'b1, 32'h0);
    repeat (4) @(posedge core_clk_i);
    cmp_bit(rvalid, 1'b0, "valid after disable");
    pulse_on <= 1'b0;
  endtask

  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      mism("timeout");
      finish_test;
    end
  end

  initial begin
    void'($urandom(32'hce52f710));
    do_reset;
    for (int i = 0; i < 5; i++) begin
      apb(12'(4 * i), 1'b0, 32'h0);
      cmp_val(rd, re[i], "reset value");
    end
    for (int i = 0; i < 9; i++) begin
      apb(ta[i], 1'b1, tw[i]);
      apb(ta[i], 1'b0, 32'h0);
      cmp_val(rd, te[i], "register range");
    end
    apb(12'h040, 1'b0, 32'h0);
    cmp_bit(er, 1'b1, "unmapped refused");
    apb(12'h104, 1'b1, 32'h0);
    cmp_bit(er, 1'b1, "high address refused");
    for (int i = 0; i < 8; i++) begin
      en = 1'($urandom);
      pl = 1'($urandom);
      apb(12'h000, 1'b1, {22'h0, 2'h2, 5'h0, pl, 1'b0, en});
      lvl <= 1'($urandom);
      repeat (10) @(posedge core_clk_i);
      cmp_bit(active, en & (lvl == pl), "static level");
      apb(12'h014, 1'b0, 32'h0);
      cmp_val(rd, {29'h0, lvl, 1'b0, en & (lvl == pl)}, "status register");
    end
    run_pfm(0, 0, 0, 2, 0);
    run_pfm(1, -100000, 900000, 1, 2);
    run_pfm(2, -100000, 900000, 0, 0);
    finish_test;
  end
endmodule // binary_input_pulse_frequency_reader_test
`default_nettype wire
